//--- rtl/oag_operand_address_generator.sv
`timescale 1ns/1ps
module oag_operand_address_generator (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic start,
  input wire oag_pkg::oag_mode_e mode,
  input wire logic use_y,
  input wire logic rmw,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] x_reg,
  input wire logic [15:0] y_reg,
  input wire logic [15:0] pc,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [15:0] ea,
  output logic [15:0] target,
  output logic [7:0] imm_value,
  output logic [1:0] op_len,
  output logic [1:0] int_mask,
  output logic trap_req,
  output logic wait_req,
  output logic halt_req
);
  import oag_pkg::*;

  // ----------------------------------------------------------------
  // mode classification
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OAG_IDLE, OAG_FETCH, OAG_FINISH} oag_state_e;
  oag_state_e st_q;
  oag_mode_e mode_q;
  logic use_y_q;
  logic [7:0] b1_q, b2_q;
  logic [15:0] idx_q, pc_q;
  logic [15:0] ea_q, target_q;
  logic [7:0] imm_q;
  logic [1:0] len_q, mask_q;
  logic done_q, illegal_q, trap_q, wait_q, halt_q;
  oag_ctl_e ctl;

  oag_ptr_if ptr ();

  wire is_long = (mode == OAG_DIR_LONG) || (mode == OAG_IDX_LONG) ||
                 (mode == OAG_IND_LONG) || (mode == OAG_INDIDX_LONG);
  wire rmw_bad = rmw && is_long;
  wire q_indirect = (mode_q == OAG_IND_SHORT) || (mode_q == OAG_IND_LONG) ||
                    (mode_q == OAG_INDIDX_SHORT) || (mode_q == OAG_INDIDX_LONG) ||
                    (mode_q == OAG_REL_INDIRECT) || (mode_q == OAG_BIT_INDIRECT) ||
                    (mode_q == OAG_BITREL_INDIRECT);
  wire q_word_ptr = (mode_q == OAG_IND_LONG) || (mode_q == OAG_INDIDX_LONG);
  wire [15:0] idx_sel = use_y ? y_reg : x_reg;
  // short modes only use the low byte of the index
  wire [15:0] idx_short = oag_pz(idx_q[7:0]);

  // ----------------------------------------------------------------
  // address arithmetic
  // ----------------------------------------------------------------
  // byte plus byte cannot wrap past 1FE since the sum keeps the carry
  wire [15:0] short_idx_sum = idx_short + oag_pz(b1_q);
  wire [15:0] long_idx_sum = idx_q + {b1_q, b2_q};
  wire [15:0] ptr_idx_short = idx_short + ptr.value;
  wire [15:0] ptr_idx_long = idx_q + ptr.value;
  wire [7:0] rel_ofs = (mode_q == OAG_REL_INDIRECT) ? ptr.value[7:0] : b1_q;
  wire [15:0] rel_target = pc_q + {{8{rel_ofs[7]}}, rel_ofs};

  logic [15:0] ea_d;
  always_comb begin
    ea_d = OAG_ADDR_RESET;
    case (mode_q)
      OAG_INHERENT, OAG_IMMEDIATE: ea_d = OAG_ADDR_RESET;
      OAG_DIR_SHORT, OAG_BIT_DIRECT, OAG_BITREL_DIRECT: ea_d = oag_pz(b1_q);
      OAG_DIR_LONG: ea_d = {b1_q, b2_q};
      OAG_IDX_NOOFS: ea_d = idx_short;
      OAG_IDX_SHORT: ea_d = short_idx_sum;
      OAG_IDX_LONG: ea_d = long_idx_sum;
      OAG_IND_SHORT, OAG_BIT_INDIRECT, OAG_BITREL_INDIRECT:
        ea_d = oag_pz(ptr.value[7:0]);
      OAG_IND_LONG: ea_d = ptr.value;
      OAG_INDIDX_SHORT: ea_d = ptr_idx_short;
      OAG_INDIDX_LONG: ea_d = ptr_idx_long;
      OAG_REL_DIRECT, OAG_REL_INDIRECT: ea_d = rel_target;
      default: ea_d = OAG_ADDR_RESET;
    endcase
  end

  // bit-test-and-branch offset is the last trailing byte, held in b2_q for both variants;
  // the first trailing byte is the operand address (direct) or the pointer address (indirect), never the offset
  wire [7:0] btb_ofs = b2_q;
  wire [15:0] btb_target = pc_q + {{8{btb_ofs[7]}}, btb_ofs};
  wire q_btb = (mode_q == OAG_BITREL_DIRECT) || (mode_q == OAG_BITREL_INDIRECT);

  // ----------------------------------------------------------------
  // control instruction decode and pointer fetcher
  // ----------------------------------------------------------------
  oag_ctl_decode u_ctl (
    .opcode(opcode),
    .is_inherent(mode == OAG_INHERENT),
    .ctl(ctl)
  );

  assign ptr.req = (st_q == OAG_FETCH);
  assign ptr.word = q_word_ptr;
  assign ptr.addr = b1_q;

  oag_ptr_fetch u_fetch (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .p(ptr.fetcher),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= OAG_IDLE;
      mode_q <= OAG_INHERENT;
      use_y_q <= 1'b0;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      idx_q <= OAG_ADDR_RESET;
      pc_q <= OAG_ADDR_RESET;
      len_q <= OAG_LEN_RESET;
    end else if (clk_en) begin
      case (st_q)
        OAG_IDLE: if (start && !rmw_bad) begin
          mode_q <= mode;
          use_y_q <= use_y;
          idx_q <= idx_sel;
          pc_q <= pc;
          len_q <= oag_len(mode);
          // third trailing byte, byte3, carries the branch offset of the indirect bit-test-and-branch
          b1_q <= byte1;
          b2_q <= (mode == OAG_BITREL_INDIRECT) ? byte3 : byte2;
          st_q <= OAG_FINISH;
          if (mode == OAG_IND_SHORT || mode == OAG_IND_LONG ||
              mode == OAG_INDIDX_SHORT || mode == OAG_INDIDX_LONG ||
              mode == OAG_REL_INDIRECT || mode == OAG_BIT_INDIRECT ||
              mode == OAG_BITREL_INDIRECT) st_q <= OAG_FETCH;
        end
        OAG_FETCH: if (ptr.done) st_q <= OAG_FINISH;
        OAG_FINISH: st_q <= OAG_IDLE;
        default: st_q <= OAG_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ea_q <= OAG_ADDR_RESET;
      target_q <= OAG_ADDR_RESET;
      imm_q <= 8'h00;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      mask_q <= OAG_MASK_LEVEL_SET;
      trap_q <= 1'b0;
      wait_q <= 1'b0;
      halt_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= (st_q == OAG_FINISH);
      illegal_q <= (st_q == OAG_IDLE) && start && rmw_bad;
      trap_q <= 1'b0;
      wait_q <= 1'b0;
      halt_q <= 1'b0;
      if (st_q == OAG_IDLE && start && !rmw_bad) begin
        imm_q <= (mode == OAG_IMMEDIATE) ? byte1 : 8'h00;
        if (ctl == OAG_CTL_SET_MASK) mask_q <= OAG_MASK_LEVEL_SET;
        if (ctl == OAG_CTL_CLR_MASK) mask_q <= OAG_MASK_LEVEL_CLR;
        trap_q <= (ctl == OAG_CTL_TRAP);
        wait_q <= (ctl == OAG_CTL_WAIT);
        halt_q <= (ctl == OAG_CTL_HALT);
      end
      if (st_q == OAG_FINISH) begin
        ea_q <= ea_d;
        target_q <= q_btb ? btb_target : ea_d;
      end
    end
  end

  assign busy = (st_q != OAG_IDLE);
  assign done = done_q;
  assign illegal = illegal_q;
  assign ea = ea_q;
  assign target = target_q;
  assign imm_value = imm_q;
  assign op_len = len_q;
  assign int_mask = mask_q;
  assign trap_req = trap_q;
  assign wait_req = wait_q;
  assign halt_req = halt_q;
  wire unused_ok = use_y_q | q_indirect;
endmodule

//--- rtl/oag_pkg.sv
package oag_pkg;

  // ----------------------------------------------------------------
  // addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OAG_INHERENT,
    OAG_IMMEDIATE,
    OAG_DIR_SHORT,
    OAG_DIR_LONG,
    OAG_IDX_NOOFS,
    OAG_IDX_SHORT,
    OAG_IDX_LONG,
    OAG_IND_SHORT,
    OAG_IND_LONG,
    OAG_INDIDX_SHORT,
    OAG_INDIDX_LONG,
    OAG_REL_DIRECT,
    OAG_REL_INDIRECT,
    OAG_BIT_DIRECT,
    OAG_BIT_INDIRECT,
    OAG_BITREL_DIRECT,
    OAG_BITREL_INDIRECT
  } oag_mode_e;

  // one-byte control instructions decoded from the full 8-bit opcode in inherent mode
  typedef enum logic [2:0] {
    OAG_CTL_NONE,
    OAG_CTL_SET_MASK,
    OAG_CTL_CLR_MASK,
    OAG_CTL_TRAP,
    OAG_CTL_WAIT,
    OAG_CTL_HALT
  } oag_ctl_e;

  localparam int OAG_MODE_COUNT = 17;
  localparam logic [7:0] OAG_PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] OAG_ADDR_RESET = 16'h0000;
  localparam logic [1:0] OAG_MASK_LEVEL_SET = 2'h3;
  localparam logic [1:0] OAG_MASK_LEVEL_CLR = 2'h0;
  localparam logic [1:0] OAG_LEN_RESET = 2'h0;

  // bytes following the opcode for each mode
  function automatic logic [1:0] oag_len(input oag_mode_e m);
    case (m)
      OAG_INHERENT, OAG_IDX_NOOFS: oag_len = 2'd0;
      OAG_IMMEDIATE, OAG_DIR_SHORT, OAG_IDX_SHORT, OAG_REL_DIRECT,
      OAG_BIT_DIRECT: oag_len = 2'd1;
      OAG_BITREL_INDIRECT: oag_len = 2'd3;
      default: oag_len = 2'd2;
    endcase
  endfunction

  // page-zero expansion of a single byte
  function automatic logic [15:0] oag_pz(input logic [7:0] b);
    oag_pz = {OAG_PAGE_ZERO_HI, b};
  endfunction

endpackage

//--- rtl/oag_ptr_if.sv
`timescale 1ns/1ps
interface oag_ptr_if;
  logic req;
  logic word;
  logic [7:0] addr;
  logic done;
  logic [15:0] value;
  modport master (output req, output word, output addr, input done, input value);
  modport fetcher (input req, input word, input addr, output done, output value);
endinterface

//--- rtl/oag_ptr_fetch.sv
`timescale 1ns/1ps
module oag_ptr_fetch (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  oag_ptr_if.fetcher p,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  import oag_pkg::*;

  typedef enum logic [1:0] {OAG_PF_IDLE, OAG_PF_HI, OAG_PF_LO} oag_pf_e;
  oag_pf_e st_q;
  logic [7:0] hi_q;
  logic [15:0] val_q;
  logic done_q;
  logic [7:0] next_ptr;

  assign next_ptr = p.addr + 8'h01;
  // pointer lives in page zero, word pointers are high byte first
  assign mem_req = (st_q != OAG_PF_IDLE);
  assign mem_addr = (st_q == OAG_PF_LO && p.word) ? oag_pz(next_ptr) : oag_pz(p.addr);
  assign p.done = done_q;
  assign p.value = val_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= OAG_PF_IDLE;
      hi_q <= 8'h00;
      val_q <= OAG_ADDR_RESET;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      case (st_q)
        OAG_PF_IDLE: if (p.req && !done_q) st_q <= p.word ? OAG_PF_HI : OAG_PF_LO;
        OAG_PF_HI: if (mem_ack) begin
          hi_q <= mem_rdata;
          st_q <= OAG_PF_LO;
        end
        OAG_PF_LO: if (mem_ack) begin
          val_q <= p.word ? {hi_q, mem_rdata} : oag_pz(mem_rdata);
          done_q <= 1'b1;
          st_q <= OAG_PF_IDLE;
        end
        default: st_q <= OAG_PF_IDLE;
      endcase
    end
  end
endmodule

//--- rtl/oag_ctl_decode.sv
`timescale 1ns/1ps
module oag_ctl_decode (
  input wire logic [7:0] opcode,
  input wire logic is_inherent,
  output oag_pkg::oag_ctl_e ctl
);
  import oag_pkg::*;

  // opcode values of the control instructions are fixed localparams of the decoder
  localparam logic [7:0] OP_SET_MASK = 8'h9B;
  localparam logic [7:0] OP_CLR_MASK = 8'h9A;
  localparam logic [7:0] OP_TRAP = 8'h83;
  localparam logic [7:0] OP_WAIT = 8'h8F;
  localparam logic [7:0] OP_HALT = 8'h8E;

  assign ctl = !is_inherent ? OAG_CTL_NONE :
               (opcode == OP_SET_MASK) ? OAG_CTL_SET_MASK :
               (opcode == OP_CLR_MASK) ? OAG_CTL_CLR_MASK :
               (opcode == OP_TRAP) ? OAG_CTL_TRAP :
               (opcode == OP_WAIT) ? OAG_CTL_WAIT :
               (opcode == OP_HALT) ? OAG_CTL_HALT : OAG_CTL_NONE;
endmodule

//--- verif/oag_properties.sv
`timescale 1ns/1ps
module oag_properties (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic start,
  input wire oag_pkg::oag_mode_e mode,
  input wire logic use_y,
  input wire logic rmw,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [15:0] x_reg,
  input wire logic [15:0] y_reg,
  input wire logic [15:0] pc,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire logic [15:0] ea,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr
);
  import oag_pkg::*;
  wire lng = mode inside {OAG_DIR_LONG, OAG_IDX_LONG, OAG_IND_LONG, OAG_INDIDX_LONG};
  wire ptr = mode inside {OAG_IND_SHORT, OAG_IND_LONG, OAG_INDIDX_SHORT, OAG_INDIDX_LONG,
    OAG_REL_INDIRECT, OAG_BIT_INDIRECT, OAG_BITREL_INDIRECT};
  wire ask = clk_en & start & ~busy;
  wire tk = ask & ~(rmw & lng);
  wire [7:0] ilo = use_y ? y_reg[7:0] : x_reg[7:0];
  wire [15:0] ixs = {8'h00, ilo} + {8'h00, byte1};
  wire [15:0] ixl = (use_y ? y_reg : x_reg) + {byte1, byte2};
  wire [15:0] rel = pc + {{8{byte1[7]}}, byte1};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_BUSY: assert property (tk |=> busy)
    else $error("busy not raised");
  AST_DONE: assert property (tk && !ptr |-> ##2 done)
    else $error("done late");
  AST_ILL: assert property (ask && rmw && lng |=> illegal && !busy)
    else $error("long rmw accepted");
  AST_DS: assert property (tk && mode == OAG_DIR_SHORT |-> ##2 ea == {8'h00, $past(byte1, 2)})
    else $error("short direct address");
  AST_DL: assert property (tk && mode == OAG_DIR_LONG |-> ##2 ea == $past({byte1, byte2}, 2))
    else $error("long direct address");
  AST_IXS: assert property (tk && mode == OAG_IDX_SHORT |-> ##2 ea == $past(ixs, 2))
    else $error("short indexed address");
  AST_IXL: assert property (tk && mode == OAG_IDX_LONG |-> ##2 ea == $past(ixl, 2))
    else $error("long indexed address");
  AST_REL: assert property (tk && mode == OAG_REL_DIRECT |-> ##2 ea == $past(rel, 2))
    else $error("relative target");
  AST_PTR: assert property (tk && ptr |-> ##2 mem_req && mem_addr == {8'h00, $past(byte1, 2)})
    else $error("pointer fetch address");
  cover property (tk && ptr);
  cover property (illegal);
  cover property (tk && mode == OAG_IDX_SHORT && ixs[8]);
endmodule
bind oag_operand_address_generator oag_properties u_props (.core_clk, .rst, .clk_en, .start,
  .mode, .use_y, .rmw, .byte1, .byte2, .x_reg, .y_reg, .pc, .busy, .done, .illegal, .ea,
  .mem_req, .mem_addr);

//--- verif/oag_mem_model.sv
`timescale 1ns/1ps
module oag_mem_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] dly,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [1:0] wait_q;
  logic ack_q;
  logic [7:0] data_q;
  wire hit = mem_req & ~ack_q & (wait_q == dly);
  assign mem_ack = ack_q;
  assign mem_rdata = data_q;
  // data toggles off the ack cycle so a stale byte never passes for a fresh one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 2'h0;
      ack_q <= 1'b0;
      data_q <= 8'h00;
    end else begin
      ack_q <= hit;
      data_q <= hit ? (mem_addr[7:0] ^ 8'hA5) : ~data_q;
      wait_q <= (mem_req && !ack_q && !hit) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

//--- verif/oag_operand_address_generator_tb_top.sv
`timescale 1ns/1ps
module oag_operand_address_generator_tb_top;
  import oag_pkg::*;
  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
  localparam int LEN [17] = '{0, 1, 1, 2, 0, 1, 2, 2, 2, 2, 2, 1, 2, 1, 2, 2, 3};
  logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, start = 1'b0, use_y = 1'b0, rmw = 1'b0;
  oag_mode_e mode = OAG_INHERENT;
  logic [7:0] opcode = 8'h00, byte1 = 8'h00, byte2 = 8'h00, byte3 = 8'h00, mem_rdata, imm_value;
  logic [15:0] x_reg = 16'h12AB, y_reg = 16'h34FF, pc = 16'h1000, mem_addr, ea, target;
  logic [1:0] dly = 2'h0, op_len, int_mask;
  logic mem_req, mem_ack, busy, done, illegal, trap_req, wait_req, halt_req;
  logic saw_clr = 1'b0, saw_set = 1'b0;
  int n_fail = 0, n_tests = 0, n_trap = 0, n_wait = 0, n_halt = 0, n_bad = 0;
  always #5 core_clk = ~core_clk;
  oag_operand_address_generator DUT (.core_clk, .rst, .clk_en, .start, .mode, .use_y, .rmw,
    .opcode, .byte1, .byte2, .byte3, .x_reg, .y_reg, .pc, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata, .busy, .done, .illegal, .ea, .target, .imm_value, .op_len, .int_mask,
    .trap_req, .wait_req, .halt_req);
  oag_mem_model u_mem (.core_clk, .rst, .dly, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
  always @(negedge core_clk) begin
    n_trap += int'(trap_req === 1'b1);
    n_wait += int'(wait_req === 1'b1);
    n_halt += int'(halt_req === 1'b1);
    n_bad += int'(int_mask === 2'h1 || int_mask === 2'h2);
    if (int_mask === 2'h0)
      saw_clr = 1'b1;
    if (saw_clr && int_mask === 2'h3)
      saw_set = 1'b1;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic go(oag_mode_e m, logic [7:0] op, logic [7:0] b1, logic [7:0] b2,
                    logic y, logic r);
    int i;
    @(posedge core_clk);
    mode <= m;
    opcode <= op;
    byte1 <= b1;
    byte2 <= b2;
    use_y <= y;
    rmw <= r;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    for (i = 0; i < 40 && done !== 1'b1 && illegal !== 1'b1; i++)
      @(negedge core_clk);
    if (i == 40) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic ea_is(oag_mode_e m, logic [7:0] b1, logic [7:0] b2, logic y, logic [15:0] e);
    go(m, 8'h00, b1, b2, y, 1'b0);
    `CHK(ea, e)
  endtask
  task automatic t_ctl();
    `CHK(int_mask, 2'h3)
    for (int k = 0; k < 512; k++) begin
      go(OAG_INHERENT, k[7:0], 8'h00, 8'h00, 1'b0, 1'b0);
      `CHK(op_len, 2'h0)
    end
    `CHK(saw_set, 1'b1)
    `CHK(n_bad, 0)
    `CHK(n_trap, 2)
    `CHK(n_wait, 2)
    `CHK(n_halt, 2)
    $display("control test done");
  endtask
  task automatic t_len();
    for (int m = 0; m < 17; m++) begin
      go(oag_mode_e'(m), 8'h00, 8'h10, 8'h20, 1'b0, 1'b0);
      `CHK(op_len, 2'(LEN[m]))
    end
    $display("length test done");
  endtask
  task automatic t_addr();
    ea_is(OAG_DIR_SHORT, 8'hC3, 8'h5A, 1'b0, 16'h00C3);
    ea_is(OAG_DIR_LONG, 8'h12, 8'h34, 1'b0, 16'h1234);
    ea_is(OAG_IDX_NOOFS, 8'h77, 8'h00, 1'b0, 16'h00AB);
    ea_is(OAG_IDX_SHORT, 8'hFF, 8'h00, 1'b1, 16'h01FE);
    ea_is(OAG_IDX_LONG, 8'h40, 8'h01, 1'b0, 16'h52AC);
    ea_is(OAG_REL_DIRECT, 8'h80, 8'h00, 1'b0, 16'h0F80);
    ea_is(OAG_REL_DIRECT, 8'h7F, 8'h00, 1'b0, 16'h107F);
    `CHK(target, 16'h107F)
    ea_is(OAG_BITREL_DIRECT, 8'h10, 8'h05, 1'b0, 16'h0010);
    `CHK(target, 16'h1005)
    ea_is(OAG_BIT_DIRECT, 8'hE7, 8'h00, 1'b0, 16'h00E7);
    go(OAG_IMMEDIATE, 8'h00, 8'h5A, 8'h00, 1'b0, 1'b0);
    `CHK(imm_value, 8'h5A)
    $display("address test done");
  endtask
  task automatic t_ptr();
    @(posedge core_clk);
    dly <= 2'h2;
    ea_is(OAG_IND_SHORT, 8'h10, 8'h00, 1'b0, 16'h00B5);
    ea_is(OAG_IND_LONG, 8'hFF, 8'h00, 1'b0, 16'h5AA5);
    ea_is(OAG_INDIDX_SHORT, 8'h20, 8'h00, 1'b1, 16'h0184);
    ea_is(OAG_INDIDX_LONG, 8'h30, 8'h00, 1'b0, 16'hA83F);
    ea_is(OAG_REL_INDIRECT, 8'h40, 8'h00, 1'b0, 16'h0FE5);
    $display("pointer test done");
  endtask
  task automatic t_rmw();
    go(OAG_IND_LONG, 8'h00, 8'h10, 8'h00, 1'b0, 1'b1);
    `CHK(illegal, 1'b1)
    `CHK(busy, 1'b0)
    go(OAG_DIR_SHORT, 8'h00, 8'h44, 8'h00, 1'b0, 1'b1);
    `CHK(ea, 16'h0044)
    $display("rmw test done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_ctl();
    t_len();
    t_addr();
    t_ptr();
    t_rmw();
    conclude();
  end
endmodule
